// File: core/trig_io_cond.sv
// Trigger conditioning, general inputs and outputs, strobe and shaft encoder
// Function
// - Each of four inputs is readable by software and raises its own interrupt.
// - Inputs 1 and 2 may each be chosen as external trigger source.
// - Trigger debounce time is programmable from 1 to 255 microseconds.
// - Trigger pulses shorter than the debounce time are discarded entirely.
// - A debounce value of zero acts as one microsecond.
// - A software trigger request acts like a validated external trigger.
// - Input 2 gives the second pulse closing a variable-length frame.
// - Software selects input level: differential, TTL, 12 V or 24 V.
// - Differential input 1 masks the other three inputs from reading and interrupts; input 2 still feeds the trigger logic.
// - Eight tri-state outputs stay undriven until software enables them.
// - Outputs 1 and 2 carry strobes with enable, polarity, method, delay, width.
// - Quadrature phases A and B are followed at up to 10 MHz.
module trig_io_cond
  import trig_io_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] gp_in_pin,
  input wire logic enc_a_pin,
  input wire logic enc_b_pin,
  output logic [7:0] gp_out,
  output logic [7:0] gp_out_oe,
  output logic [1:0] in_level_sel,
  output logic [1:0] enc_level_sel,
  output logic trig_valid,
  output logic frame_end,
  output logic line_trig,
  output logic irq
);
  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic [7:0] dbt_limit(input logic [7:0] v);
    dbt_limit = (v == 8'h00) ? DEBOUNCE_MIN : v;
  endfunction

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [3:0] in_s1, in_s2, in_prev;
  logic [1:0] enc_s1, enc_s2, enc_prev;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      in_s1 <= 4'h0;
      in_s2 <= 4'h0;
      in_prev <= 4'h0;
      enc_s1 <= 2'h0;
      enc_s2 <= 2'h0;
      enc_prev <= 2'h0;
    end else begin
      in_s1 <= gp_in_pin;
      in_s2 <= in_s1;
      in_prev <= in_s2;
      enc_s1 <= {enc_a_pin, enc_b_pin};
      enc_s2 <= enc_s1;
      enc_prev <= enc_s2;
    end
  end

  // ------------------------------------------------------------
  // Register file state
  // ------------------------------------------------------------
  ctrl_t ctrl_reg, ctrl_next;
  strobe_t stb_reg, stb_next;
  logic [7:0] dbt_reg, dbt_next, skip_reg, skip_next;
  logic [15:0] gpo_reg, gpo_next, wait_reg, wait_next, width_reg, width_next;
  logic [INT_W-1:0] stat_reg, stat_next, mask_reg, mask_next, stat_set;
  logic soft_reg, soft_next;
  logic [31:0] prdata_next, pos_reg;
  logic [3:0] usable;
  logic wr_acc, rd_setup, mapped;

  assign usable = (ctrl_reg.trig_input_level == LVL_DIFF) ? 4'h1 : 4'hf;
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_INT_MASK);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign irq = |(stat_reg & mask_reg);
  assign in_level_sel = ctrl_reg.trig_input_level;
  assign enc_level_sel = ctrl_reg.encoder_input_level;

  always_comb begin
    ctrl_next = ctrl_reg;
    stb_next = stb_reg;
    dbt_next = dbt_reg;
    skip_next = skip_reg;
    gpo_next = gpo_reg;
    wait_next = wait_reg;
    width_next = width_reg;
    mask_next = mask_reg;
    soft_next = 1'b0;
    stat_next = stat_reg;
    prdata_next = prdata;
    if (wr_acc) begin
      case (paddr)
        OFS_CTRL: ctrl_next = pwdata[9:0];
        OFS_DEBOUNCE: dbt_next = pwdata[7:0];
        OFS_SWTRIG: soft_next = pwdata[0];
        OFS_GPOUT: gpo_next = pwdata[15:0];
        OFS_STROBE: stb_next = pwdata[3:0];
        OFS_STB_WAIT: wait_next = pwdata[15:0];
        OFS_STB_WIDTH: width_next = pwdata[15:0];
        OFS_ENC_SKIP: skip_next = pwdata[7:0];
        OFS_INT_MASK: mask_next = pwdata[INT_W-1:0];
        default: ;
      endcase
    end
    if (psel && penable && !pwrite && paddr == OFS_INT_STAT) begin
      stat_next = stat_reg & ~prdata[INT_W-1:0];
    end
    stat_next = stat_next | stat_set;
    if (rd_setup && !pwrite) begin
      case (paddr)
        OFS_CTRL: prdata_next = {22'h0, ctrl_reg};
        OFS_DEBOUNCE: prdata_next = {24'h0, dbt_reg};
        OFS_GPIN: prdata_next = {28'h0, in_s2 & usable};
        OFS_GPOUT: prdata_next = {16'h0, gpo_reg};
        OFS_STROBE: prdata_next = {28'h0, stb_reg};
        OFS_STB_WAIT: prdata_next = {16'h0, wait_reg};
        OFS_STB_WIDTH: prdata_next = {16'h0, width_reg};
        OFS_ENC_POS: prdata_next = pos_reg;
        OFS_ENC_SKIP: prdata_next = {24'h0, skip_reg};
        OFS_INT_STAT: prdata_next = {25'h0, stat_reg};
        OFS_INT_MASK: prdata_next = {25'h0, mask_reg};
        default: prdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl_reg <= CTRL_RST;
      stb_reg <= STROBE_RST;
      dbt_reg <= DEBOUNCE_RST;
      skip_reg <= 8'h00;
      gpo_reg <= GPOUT_RST;
      wait_reg <= 16'h0000;
      width_reg <= STB_TIME_RST;
      mask_reg <= 7'h00;
      stat_reg <= 7'h00;
      soft_reg <= 1'b0;
      prdata <= 32'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      stb_reg <= stb_next;
      dbt_reg <= dbt_next;
      skip_reg <= skip_next;
      gpo_reg <= gpo_next;
      wait_reg <= wait_next;
      width_reg <= width_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      soft_reg <= soft_next;
      prdata <= prdata_next;
    end
  end

  // ------------------------------------------------------------
  // Trigger debounce and validation
  // ------------------------------------------------------------
  logic [1:0] lvl_reg, lvl_next, db_edge;
  logic [6:0] sub_reg [2], sub_next [2];
  logic [7:0] us_reg [2], us_next [2];
  logic frame_reg, frame_next, trig_next, fend_next, ext_trig;

  always_comb begin
    lvl_next = lvl_reg;
    db_edge = 2'b00;
    for (int i = 0; i < 2; i++) begin
      sub_next[i] = 7'h00;
      us_next[i] = 8'h00;
      if (in_s2[i] != lvl_reg[i]) begin
        sub_next[i] = sub_reg[i] + 7'h01;
        us_next[i] = us_reg[i];
        if (sub_reg[i] == TICK_LAST) begin
          sub_next[i] = 7'h00;
          us_next[i] = us_reg[i] + 8'h01;
          if (us_reg[i] + 8'h01 >= dbt_limit(dbt_reg)) begin
            lvl_next[i] = in_s2[i];
            us_next[i] = 8'h00;
            db_edge[i] = in_s2[i] ^ ctrl_reg.trig_edge_detect;
          end
        end
      end
    end
    ext_trig = ctrl_reg.trig_enable_flag &&
      ((ctrl_reg.trig_source_select == SRC_IN1 && db_edge[0]) ||
       (ctrl_reg.trig_source_select == SRC_IN2 && db_edge[1] && !ctrl_reg.two_pulse));
    fend_next = ctrl_reg.trig_enable_flag && ctrl_reg.two_pulse && frame_reg && db_edge[1];
    trig_next = ext_trig || soft_reg;
    frame_next = frame_reg;
    if (fend_next || !ctrl_reg.two_pulse) begin
      frame_next = 1'b0;
    end else if (trig_next) begin
      frame_next = 1'b1;
    end
    stat_set = {line_trig, frame_end, trig_valid, (in_s2 ^ in_prev) & usable};
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      lvl_reg <= 2'b00;
      sub_reg <= '{7'h00, 7'h00};
      us_reg <= '{8'h00, 8'h00};
      frame_reg <= 1'b0;
      trig_valid <= 1'b0;
      frame_end <= 1'b0;
    end else begin
      lvl_reg <= lvl_next;
      sub_reg <= sub_next;
      us_reg <= us_next;
      frame_reg <= frame_next;
      trig_valid <= trig_next;
      frame_end <= fend_next;
    end
  end

  // ------------------------------------------------------------
  // Strobe sequencer and general outputs
  // ------------------------------------------------------------
  stb_state_t stb_state, stb_state_nx;
  logic [6:0] ssub_reg, ssub_next;
  logic [15:0] sus_reg, sus_next;
  logic [7:0] gp_out_next;
  logic stb_start, stb_lvl;

  always_comb begin
    stb_state_nx = stb_state;
    ssub_next = ssub_reg;
    sus_next = sus_reg;
    stb_start = (|stb_reg.strobe_on) && (stb_reg.strobe_method ? frame_end : trig_valid);
    case (stb_state)
      STB_IDLE: begin
        ssub_next = 7'h00;
        sus_next = 16'h0000;
        if (stb_start) begin
          stb_state_nx = (wait_reg == 16'h0000) ? STB_ACTIVE : STB_WAIT;
        end
      end
      STB_WAIT, STB_ACTIVE: begin
        ssub_next = ssub_reg + 7'h01;
        if (ssub_reg == TICK_LAST) begin
          ssub_next = 7'h00;
          sus_next = sus_reg + 16'h0001;
          if (stb_state == STB_WAIT && sus_reg + 16'h0001 >= wait_reg) begin
            stb_state_nx = STB_ACTIVE;
            sus_next = 16'h0000;
          end else if (stb_state == STB_ACTIVE && sus_reg + 16'h0001 >= width_reg) begin
            stb_state_nx = STB_IDLE;
          end
        end
      end
      default: stb_state_nx = STB_IDLE;
    endcase
    stb_lvl = (stb_state == STB_ACTIVE) ^ stb_reg.strobe_pol;
    gp_out_next = gpo_reg[7:0];
    for (int k = 0; k < 2; k++) begin
      if (stb_reg.strobe_on[k]) begin
        gp_out_next[k] = stb_lvl;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stb_state <= STB_IDLE;
      ssub_reg <= 7'h00;
      sus_reg <= 16'h0000;
      gp_out <= 8'h00;
      gp_out_oe <= 8'h00;
    end else begin
      stb_state <= stb_state_nx;
      ssub_reg <= ssub_next;
      sus_reg <= sus_next;
      gp_out <= gp_out_next;
      gp_out_oe <= gpo_reg[15:8];
    end
  end

  // ------------------------------------------------------------
  // Quadrature decoder
  // ------------------------------------------------------------
  logic [31:0] pos_next;
  logic [7:0] skc_reg, skc_next;
  logic step, up, line_next;

  always_comb begin
    step = ctrl_reg.encoder_on && (enc_s2 != enc_prev) && (enc_s2 != ~enc_prev);
    up = enc_s2[1] ^ enc_prev[0];
    pos_next = pos_reg;
    skc_next = skc_reg;
    line_next = 1'b0;
    if (step) begin
      pos_next = up ? pos_reg + 32'h1 : pos_reg - 32'h1;
      if (up) begin
        skc_next = skc_reg + 8'h01;
        if (skc_reg >= skip_reg) begin
          skc_next = 8'h00;
          line_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pos_reg <= 32'h0;
      skc_reg <= 8'h00;
      line_trig <= 1'b0;
    end else begin
      pos_reg <= pos_next;
      skc_reg <= skc_next;
      line_trig <= line_next;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_in_irq;
    @(posedge core_clk) disable iff (!nrst)
    (in_s2[0] != in_prev[0]) |=> stat_reg[0];
  endproperty
  a_in_irq: assert property (p_in_irq) else $error("input change lost");
  property p_src2;
    @(posedge core_clk) disable iff (!nrst)
    (ctrl_reg.trig_enable_flag && ctrl_reg.trig_source_select == SRC_IN2
     && !ctrl_reg.two_pulse && db_edge[1]) |=> trig_valid;
  endproperty
  a_src2: assert property (p_src2) else $error("input 2 trigger lost");
  property p_short_pulse;
    @(posedge core_clk) disable iff (!nrst)
    $changed(lvl_reg[0]) |-> $past(in_s2[0], 100) == lvl_reg[0];
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse accepted");
  property p_min_dbt;
    @(posedge core_clk) disable iff (!nrst)
    (dbt_reg == 8'h00 && in_s2[0] != lvl_reg[0] && sub_reg[0] == TICK_LAST)
    |=> $changed(lvl_reg[0]);
  endproperty
  a_min_dbt: assert property (p_min_dbt) else $error("zero debounce not one us");
  property p_soft;
    @(posedge core_clk) disable iff (!nrst)
    (wr_acc && paddr == OFS_SWTRIG && pwdata[0]) |-> ##2 trig_valid;
  endproperty
  a_soft: assert property (p_soft) else $error("soft trigger lost");
  property p_frame_end;
    @(posedge core_clk) disable iff (!nrst)
    (ctrl_reg.trig_enable_flag && ctrl_reg.two_pulse && frame_reg && db_edge[1]) |=> frame_end;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame end lost");
  property p_diff;
    @(posedge core_clk) disable iff (!nrst)
    (rd_setup && !pwrite && paddr == OFS_GPIN && ctrl_reg.trig_input_level == LVL_DIFF)
    |=> prdata[3:1] == 3'h0;
  endproperty
  a_diff: assert property (p_diff) else $error("unusable input shown");
  property p_oe;
    @(posedge core_clk) disable iff (!nrst)
    (wr_acc && paddr == OFS_GPOUT) |-> ##2 gp_out_oe == $past(pwdata[15:8], 2);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_strobe;
    @(posedge core_clk) disable iff (!nrst)
    stb_reg.strobe_on[0] |=> gp_out[0] == $past(stb_lvl);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe level wrong");
  property p_enc;
    @(posedge core_clk) disable iff (!nrst)
    (step && up) |=> pos_reg == $past(pos_reg) + 32'h1;
  endproperty
  a_enc: assert property (p_enc) else $error("encoder step lost");
  property p_restart;
    @(posedge core_clk) disable iff (!nrst)
    (in_s2[1] == lvl_reg[1]) |=> sub_reg[1] == 7'h00 && us_reg[1] == 8'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("debounce not restarted");
endmodule

// File: core/trig_io_pkg.sv
// Constants, register map and types of the trigger and general I/O block
package trig_io_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);
  localparam logic [7:0] DEBOUNCE_MIN = 8'h01;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DEBOUNCE = 8'h04;
  localparam logic [7:0] OFS_SWTRIG = 8'h08;
  localparam logic [7:0] OFS_GPIN = 8'h0c;
  localparam logic [7:0] OFS_GPOUT = 8'h10;
  localparam logic [7:0] OFS_STROBE = 8'h14;
  localparam logic [7:0] OFS_STB_WAIT = 8'h18;
  localparam logic [7:0] OFS_STB_WIDTH = 8'h1c;
  localparam logic [7:0] OFS_ENC_POS = 8'h20;
  localparam logic [7:0] OFS_ENC_SKIP = 8'h24;
  localparam logic [7:0] OFS_INT_STAT = 8'h28;
  localparam logic [7:0] OFS_INT_MASK = 8'h2c;
  // ------------------------------------------------------------
  // Encodings and field positions
  // ------------------------------------------------------------
  localparam logic [1:0] LVL_DIFF = 2'h0;
  localparam logic [1:0] LVL_TTL = 2'h1;
  localparam logic [1:0] LVL_12V = 2'h2;
  localparam logic [1:0] LVL_24V = 2'h3;
  localparam logic [1:0] SRC_IN1 = 2'h0;
  localparam logic [1:0] SRC_IN2 = 2'h1;
  localparam logic [1:0] SRC_SOFT = 2'h2;
  localparam int INT_W = 7;
  localparam int INT_TRIG = 4;
  localparam int INT_FRAME_END = 5;
  localparam int INT_LINE = 6;
  // ------------------------------------------------------------
  // Types and reset values
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] encoder_input_level;
    logic encoder_on;
    logic two_pulse;
    logic trig_edge_detect;
    logic [1:0] trig_source_select;
    logic trig_enable_flag;
    logic [1:0] trig_input_level;
  } ctrl_t;
  typedef struct packed {
    logic strobe_method;
    logic strobe_pol;
    logic [1:0] strobe_on;
  } strobe_t;
  typedef enum logic [1:0] {STB_IDLE = 2'b00, STB_WAIT = 2'b01, STB_ACTIVE = 2'b11} stb_state_t;
  localparam ctrl_t CTRL_RST = 10'h101;
  localparam strobe_t STROBE_RST = 4'h0;
  localparam logic [7:0] DEBOUNCE_RST = 8'h00;
  localparam logic [15:0] GPOUT_RST = 16'h0000;
  localparam logic [15:0] STB_TIME_RST = 16'h0001;
endpackage

// File: verif/trig_io_partner.sv
// Far-side model: trigger sources, shaft encoder and output receivers
module trig_io_partner
  import trig_io_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] gp_out,
  input wire logic [7:0] gp_out_oe,
  output logic [3:0] gp_in_pin,
  output logic enc_a_pin,
  output logic enc_b_pin,
  output logic [7:0] line_lvl
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] phase;
  initial begin
    gp_in_pin = 4'h0;
    enc_a_pin = 1'b0;
    enc_b_pin = 1'b0;
    line_lvl = 8'h00;
    phase = 2'h0;
  end
  // Undriven lines toggle so a released pin never shows its last value
  always @(posedge core_clk) begin
    line_lvl <= (gp_out_oe & gp_out) | (~gp_out_oe & ~line_lvl);
  end
  task automatic set_in(input logic [3:0] v);
    @(posedge core_clk);
    gp_in_pin <= v;
  endtask
  task automatic pulse(input int idx, input int len);
    @(posedge core_clk);
    gp_in_pin[idx] <= 1'b1;
    repeat (len) @(posedge core_clk);
    gp_in_pin[idx] <= 1'b0;
  endtask
  // Quadrature steps every 3 cycles, A leads B when counting up
  task automatic step(input logic up, input int n);
    repeat (n) begin
      repeat (3) @(posedge core_clk);
      phase = up ? phase + 2'h1 : phase - 2'h1;
      enc_a_pin <= phase[1] ^ phase[0];
      enc_b_pin <= phase[1];
    end
  endtask
endmodule

// File: verif/trigger_io_conditioning_tb_top.sv
// Self-checking testbench of the trigger and general I/O block
module trigger_io_conditioning_tb_top
  import trig_io_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, enc_a_pin, enc_b_pin, trig_valid, frame_end, line_trig, irq;
  logic [3:0] gp_in_pin;
  logic [7:0] gp_out, gp_out_oe, line_lvl;
  logic [1:0] in_level_sel, enc_level_sel;
  logic [31:0] q;
  logic last_err;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_trig = 0;
  int n_frame = 0;
  int n_line = 0;
  always #5 core_clk = ~core_clk;
  trig_io_cond uut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gp_in_pin(gp_in_pin), .enc_a_pin(enc_a_pin), .enc_b_pin(enc_b_pin),
    .gp_out(gp_out), .gp_out_oe(gp_out_oe), .in_level_sel(in_level_sel),
    .enc_level_sel(enc_level_sel), .trig_valid(trig_valid), .frame_end(frame_end),
    .line_trig(line_trig), .irq(irq));
  trig_io_partner partner (.core_clk(core_clk), .gp_out(gp_out), .gp_out_oe(gp_out_oe),
    .gp_in_pin(gp_in_pin), .enc_a_pin(enc_a_pin), .enc_b_pin(enc_b_pin), .line_lvl(line_lvl));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic test_done();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (trig_valid === 1'b1) n_trig <= n_trig + 1;
    if (frame_end === 1'b1) n_frame <= n_frame + 1;
    if (line_trig === 1'b1) n_line <= n_line + 1;
    if (cycles == 40000) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: timeout", $time);
      test_done();
    end
  end
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] ctrl_word(input logic [1:0] lvl, input logic [1:0] src,
      input logic two, input logic enc, input logic [1:0] elvl);
    return {22'h0, elvl, enc, two, 1'b0, src, 1'b1, lvl};
  endfunction
  task automatic pulse_check(input int idx, input int len, input int dt, input int df);
    int t0, f0;
    t0 = n_trig;
    f0 = n_frame;
    partner.pulse(idx, len);
    repeat (300) @(posedge core_clk);
    check_val(n_trig - t0, dt, "trigger count");
    check_val(n_frame - f0, df, "frame end count");
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, OFS_CTRL, 32'h0);
    check_val(q, 32'h101, "ctrl reset");
    check_val(gp_out_oe, 8'h00, "oe after reset");
    apb(1'b0, OFS_STB_WIDTH, 32'h0);
    check_val(q, 32'h1, "width reset");
    apb(1'b0, 8'h30, 32'h0);
    check_val(q, 32'h0, "unmapped read");
    check_val(last_err, 1'b1, "unmapped error");
  endtask
  task automatic t_gpin();
    logic [1:0] lv;
    partner.set_in(4'hf);
    repeat (6) @(posedge core_clk);
    apb(1'b0, OFS_GPIN, 32'h0);
    check_val(q, 32'hf, "input levels");
    apb(1'b1, OFS_CTRL, ctrl_word(LVL_DIFF, SRC_IN1, 1'b0, 1'b0, LVL_TTL));
    apb(1'b0, OFS_GPIN, 32'h0);
    check_val(q, 32'h1, "differential masks");
    for (int i = 0; i < 4; i++) begin
      lv = 2'(i);
      apb(1'b1, OFS_CTRL, ctrl_word(lv, SRC_IN1, 1'b0, 1'b0, LVL_TTL));
      @(posedge core_clk);
      check_val(in_level_sel, lv, "input level");
    end
    partner.set_in(4'h0);
    repeat (6) @(posedge core_clk);
  endtask
  task automatic t_irq();
    apb(1'b0, OFS_INT_STAT, 32'h0);
    apb(1'b1, OFS_INT_MASK, 32'h2);
    partner.pulse(1, 10);
    repeat (6) @(posedge core_clk);
    check_val(irq, 1'b1, "irq raised");
    apb(1'b0, OFS_INT_STAT, 32'h0);
    check_val(q & 32'hf, 32'h2, "own input event");
    @(posedge core_clk);
    check_val(irq, 1'b0, "irq cleared");
    apb(1'b1, OFS_INT_MASK, 32'h0);
    partner.pulse(1, 10);
    repeat (6) @(posedge core_clk);
    check_val(irq, 1'b0, "irq masked");
  endtask
  task automatic t_debounce();
    apb(1'b1, OFS_DEBOUNCE, 32'h2);
    pulse_check(0, 150, 0, 0);
    pulse_check(0, 260, 1, 0);
    apb(1'b1, OFS_DEBOUNCE, 32'h0);
    pulse_check(0, 60, 0, 0);
    pulse_check(0, 150, 1, 0);
  endtask
  task automatic t_source();
    int t0;
    apb(1'b1, OFS_CTRL, ctrl_word(LVL_TTL, SRC_IN2, 1'b0, 1'b0, LVL_TTL));
    pulse_check(0, 200, 0, 0);
    pulse_check(1, 200, 1, 0);
    apb(1'b1, OFS_CTRL, ctrl_word(LVL_TTL, SRC_SOFT, 1'b0, 1'b0, LVL_TTL));
    pulse_check(1, 200, 0, 0);
    apb(1'b0, OFS_INT_STAT, 32'h0);
    t0 = n_trig;
    apb(1'b1, OFS_SWTRIG, 32'h1);
    repeat (5) @(posedge core_clk);
    check_val(n_trig - t0, 1, "soft trigger");
    apb(1'b0, OFS_INT_STAT, 32'h0);
    check_val(q[INT_TRIG], 1'b1, "trigger event");
  endtask
  task automatic t_two();
    apb(1'b1, OFS_CTRL, ctrl_word(LVL_TTL, SRC_IN1, 1'b1, 1'b0, LVL_TTL));
    pulse_check(0, 200, 1, 0);
    pulse_check(1, 200, 0, 1);
  endtask
  task automatic t_out();
    apb(1'b1, OFS_GPOUT, 32'hff5a);
    repeat (3) @(posedge core_clk);
    check_val({gp_out_oe, gp_out}, 16'hff5a, "outputs");
    check_val(line_lvl, 8'h5a, "driven lines");
  endtask
  task automatic t_strobe();
    int hi;
    hi = 0;
    apb(1'b1, OFS_GPOUT, 32'h0100);
    apb(1'b1, OFS_STROBE, 32'h1);
    apb(1'b1, OFS_SWTRIG, 32'h1);
    repeat (300) begin
      @(posedge core_clk);
      if (gp_out[0] === 1'b1) hi++;
    end
    check_val(hi >= 99 && hi <= 101, 1'b1, "strobe width");
    apb(1'b1, OFS_STB_WAIT, 32'h1);
    apb(1'b1, OFS_SWTRIG, 32'h1);
    repeat (60) @(posedge core_clk);
    check_val(gp_out[0], 1'b0, "strobe delayed");
    repeat (90) @(posedge core_clk);
    check_val(gp_out[0], 1'b1, "strobe after delay");
    repeat (110) @(posedge core_clk);
    check_val(gp_out[0], 1'b0, "strobe ended");
    apb(1'b1, OFS_STB_WAIT, 32'h0);
    apb(1'b1, OFS_STROBE, 32'h5);
    repeat (3) @(posedge core_clk);
    check_val(gp_out[0], 1'b1, "strobe idle inverted");
    apb(1'b1, OFS_STROBE, 32'h0);
  endtask
  task automatic t_enc();
    logic [31:0] p0;
    int l0;
    apb(1'b1, OFS_CTRL, ctrl_word(LVL_TTL, SRC_IN1, 1'b0, 1'b1, LVL_TTL));
    @(posedge core_clk);
    check_val(enc_level_sel, LVL_TTL, "encoder level ttl");
    apb(1'b1, OFS_ENC_SKIP, 32'h1);
    apb(1'b0, OFS_ENC_POS, 32'h0);
    p0 = q;
    l0 = n_line;
    partner.step(1'b1, 8);
    repeat (6) @(posedge core_clk);
    apb(1'b0, OFS_ENC_POS, 32'h0);
    check_val(q, p0 + 32'h8, "position up");
    check_val(n_line - l0, 4, "line triggers");
    partner.step(1'b0, 3);
    repeat (6) @(posedge core_clk);
    apb(1'b0, OFS_ENC_POS, 32'h0);
    check_val(q, p0 + 32'h5, "position down");
    apb(1'b1, OFS_CTRL, ctrl_word(LVL_TTL, SRC_IN1, 1'b0, 1'b1, LVL_DIFF));
    @(posedge core_clk);
    check_val(enc_level_sel, LVL_DIFF, "encoder level diff");
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_gpin();
    t_irq();
    apb(1'b1, OFS_CTRL, ctrl_word(LVL_TTL, SRC_IN1, 1'b0, 1'b0, LVL_TTL));
    t_debounce();
    t_source();
    t_two();
    t_out();
    t_strobe();
    t_enc();
    test_done();
  end
endmodule
